// ---- hw/clkgen_serial_dev.sv ----
// clock synthesizer serial slave port with its three control bytes
// assumes: link_clk_in oversamples the wires; enables are used on clk_in
//
// How it works
// - byte and block, read and write supported
// - block bytes ascend from offset zero, MSB first
// - stop after any whole byte keeps earlier bytes
// - only address byte D2h/D3h is acknowledged
// - command bit 7 picks block or byte mode
// - byte mode offset comes from command bits 6:0
// - master sends zero offset bits for blocks
// - block write: address, command, count, data, stop
// - compatibility mode drops the block write count
// - block read returns byte count before data
// - master acks data, nacks final byte, stops
// - byte write stores one byte at command offset
// - byte read returns one byte at command offset
// - byte 0 fabric pair enables, reset ones
// - byte 1 output enables, reset F6h (bits 0 and 3 zero)
// - byte 1 bit 0 spread enable, reset zero
// - byte 2 bus clock enables, reset ones
// - registers load defaults at power-up
`timescale 1ns/1ns
module clkgen_serial_dev import clkgen_pkg::*; (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic compat_mode_in,
  input wire logic link_clk_in,
  serial_link_if.dev link,
  output logic [7:0] fabric_pair_enables_out,
  output logic [7:0] misc_output_and_spread_control_out,
  output logic [7:0] bus_clock_enables_out,
  output logic spread_enable_out
);
  localparam logic [2:0][7:0] RST_REGS =
    {`RST_BUSCLK, `RST_MISC, `RST_FABRIC};

  dev_link_t s;
  dev_link_t n;
  dev_user_t u;
  dev_user_t nu;
  logic [3:0] lsync;
  logic scl_s;
  logic sda_s;
  logic ce_s;
  logic compat_s;
  logic tog_s;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  // unmapped offsets read as zero and ignore writes
  function automatic logic [7:0] rd_reg(input logic [2:0][7:0] r,
                                        input logic [6:0] p);
    rd_reg = (p < `REG_COUNT) ? r[p[1:0]] : 8'h00;
  endfunction

  // wires, clock enable and mode enter the link domain
  sync2 #(.W(4), .RST_VAL(4'hC)) u_link_sync (
    .clk_in(link_clk_in),
    .rst_in(sys_rst_in),
    .d_in({link.scl, link.sda, ce_in, compat_mode_in}),
    .q_out(lsync)
  );
  assign scl_s = lsync[3];
  assign sda_s = lsync[2];
  assign ce_s = lsync[1];
  assign compat_s = lsync[0];

  assign rise = scl_s & ~s.scl_p;
  assign fall = ~scl_s & s.scl_p;
  assign start = scl_s & s.scl_p & s.sda_p & ~sda_s;
  assign stop = scl_s & s.scl_p & ~s.sda_p & sda_s;

  always_comb begin
    n = s;
    n.scl_p = scl_s;
    n.sda_p = sda_s;
    if (start) begin
      // repeated start keeps pointer and mode from the command
      n.st = D_ADDR;
      n.cnt = 4'h0;
      n.drv = 1'b0;
    end else if (stop) begin
      // stop ends any transfer; completed bytes stay written
      n.st = D_IDLE;
      n.drv = 1'b0;
    end else begin
      case (s.st)
        D_ADDR, D_CMD, D_WDATA: begin
          if (rise && s.cnt < 4'h8) begin
            n.sh = {s.sh[6:0], sda_s};
            n.cnt = s.cnt + 4'h1;
          end
          if (fall && s.cnt == 4'h8) begin
            n.cnt = 4'h0;
            n.drv = 1'b1;
            n.st = D_ACK;
            n.after = D_WDATA;
            case (s.st)
              D_ADDR: begin
                if (s.sh[7:1] != `DEV_ADDR7) begin
                  n.drv = 1'b0;
                  n.st = D_IDLE;
                end else if (s.sh[0]) begin
                  n.after = D_SEND;
                  n.first = ~s.byte_mode;
                  n.tx = s.byte_mode ? rd_reg(s.regs, s.ptr)
                                     : {1'b0, `REG_COUNT};
                end else begin
                  n.after = D_CMD;
                end
              end
              D_CMD: begin
                n.byte_mode = s.sh[`CMD_BYTE_MODE_BIT];
                // block offset bits are expected zero and not used
                n.ptr = s.sh[`CMD_BYTE_MODE_BIT] ? s.sh[6:0]
                                                 : 7'h00;
                n.cnt_phase = ~s.sh[`CMD_BYTE_MODE_BIT]
                              & ~compat_s;
              end
              default: begin
                if (s.cnt_phase) begin
                  // byte count is acknowledged and discarded
                  n.cnt_phase = 1'b0;
                end else begin
                  if (s.ptr < `REG_COUNT) begin
                    n.regs[s.ptr[1:0]] = s.sh;
                    n.wr_tog = ~s.wr_tog;
                  end
                  if (!s.byte_mode) begin
                    n.ptr = s.ptr + 7'h01;
                  end
                end
              end
            endcase
          end
        end
        D_ACK: begin
          if (fall) begin
            n.st = s.after;
            n.drv = (s.after == D_SEND) ? ~s.tx[7] : 1'b0;
            // a send has already put out bit 7; a receive counts from zero
            n.cnt = (s.after == D_SEND) ? 4'h1 : 4'h0;
          end
        end
        D_SEND: begin
          if (fall) begin
            if (s.cnt == 4'h8) begin
              n.drv = 1'b0;
              n.st = D_MACK;
            end else begin
              n.drv = ~s.tx[~s.cnt[2:0]];
              n.cnt = s.cnt + 4'h1;
            end
          end
        end
        D_MACK: begin
          if (rise) begin
            n.acked = ~sda_s;
            if (!sda_s) begin
              if (s.first) begin
                n.first = 1'b0;
                n.tx = rd_reg(s.regs, s.ptr);
              end else if (!s.byte_mode) begin
                n.ptr = s.ptr + 7'h01;
                n.tx = rd_reg(s.regs, s.ptr + 7'h01);
              end
            end
          end
          if (fall) begin
            if (s.acked) begin
              n.st = D_SEND;
              n.drv = ~s.tx[7];
              n.cnt = 4'h1;
            end else begin
              n.st = D_IDLE;
            end
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge link_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s <= '{st: D_IDLE, after: D_IDLE, cnt: 4'h0, sh: 8'h00, tx: 8'h00,
             ptr: 7'h00, byte_mode: 1'b0, cnt_phase: 1'b0, first: 1'b0,
             acked: 1'b0, drv: 1'b0, scl_p: 1'b1, sda_p: 1'b1,
             wr_tog: 1'b0, regs: RST_REGS};
    end else if (ce_s) begin
      s <= n;
    end
  end

  // open drain: only ever pulls low
  assign link.sda_dev_o = 1'b0;
  assign link.sda_dev_oe = s.drv;

  // a register write toggles; the user side copies once it sees it
  sync2 #(.W(1), .RST_VAL(1'b0)) u_tog_sync (
    .clk_in(clk_in),
    .rst_in(sys_rst_in),
    .d_in(s.wr_tog),
    .q_out(tog_s)
  );

  always_comb begin
    nu = u;
    nu.tog_p = tog_s;
    if (tog_s != u.tog_p) begin
      nu.shadow = s.regs;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      u <= '{tog_p: 1'b0, shadow: RST_REGS};
    end else if (ce_in) begin
      u <= nu;
    end
  end

  assign fabric_pair_enables_out = u.shadow[`OFS_FABRIC];
  assign misc_output_and_spread_control_out =
    u.shadow[`OFS_MISC];
  assign bus_clock_enables_out = u.shadow[`OFS_BUSCLK];
  assign spread_enable_out = u.shadow[`OFS_MISC][`SPREAD_BIT];
endmodule // clkgen_serial_dev

// ---- hw/clkgen_defines.svh ----
// constants shared by both ends of the clock synthesizer serial port
// assumes: included by bare name from the package, the link checker and the bench
`ifndef CLKGEN_DEFINES_SVH
`define CLKGEN_DEFINES_SVH

// address byte is the 7-bit address followed by the direction bit
`define DEV_ADDR7 7'h69
`define ADDR_BYTE_WR 8'hD2
`define ADDR_BYTE_RD 8'hD3
`define CMD_BYTE_MODE_BIT 7

// register map
`define REG_COUNT 7'h03
`define OFS_FABRIC 7'h00
`define OFS_MISC 7'h01
`define OFS_BUSCLK 7'h02
`define RST_FABRIC 8'hFF
`define RST_MISC 8'hF6
`define RST_BUSCLK 8'hFF
`define SPREAD_BIT 0

// serial clock made by the master from clk_in
`define CLK_FREQ_KHZ 100000
`define SCL_FREQ_KHZ 400
`define SCL_QUARTER_CYC (`CLK_FREQ_KHZ / (`SCL_FREQ_KHZ * 4))

`endif

// ---- hw/clkgen_pkg.sv ----
// types for both ends of the clock synthesizer serial port
// assumes: clkgen_defines.svh on the include path
package clkgen_pkg;
  `include "clkgen_defines.svh"

  typedef enum logic [1:0] {
    XF_BYTE_WR,
    XF_BYTE_RD,
    XF_BLK_WR,
    XF_BLK_RD
  } xfer_kind_t;

  typedef enum logic [2:0] {
    D_IDLE,
    D_ADDR,
    D_CMD,
    D_WDATA,
    D_ACK,
    D_SEND,
    D_MACK
  } dev_phase_t;

  typedef enum logic [3:0] {
    HS_IDLE,
    HS_START,
    HS_ADDRW,
    HS_CMD,
    HS_COUNT,
    HS_WLOAD,
    HS_WDATA,
    HS_RSTART,
    HS_ADDRR,
    HS_RCOUNT,
    HS_RDATA,
    HS_STOP
  } host_state_t;

  typedef struct packed {
    dev_phase_t st;
    dev_phase_t after;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [6:0] ptr;
    logic byte_mode;
    logic cnt_phase;
    logic first;
    logic acked;
    logic drv;
    logic scl_p;
    logic sda_p;
    logic wr_tog;
    logic [2:0][7:0] regs;
  } dev_link_t;

  typedef struct packed {
    logic tog_p;
    logic [2:0][7:0] shadow;
  } dev_user_t;

  typedef struct packed {
    host_state_t st;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [8:0] div;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] rem;
    xfer_kind_t kind;
    logic [6:0] ofs;
    logic compat;
    logic nacked;
    logic scl_lvl;
    logic sda_lvl;
    logic [7:0] rd_data;
    logic rd_valid;
    logic done;
    logic err;
  } host_t;
endpackage

// ---- hw/serial_link_if.sv ----
// two-wire link between the bus master and the clock synthesizer port
// assumes: both wires are open drain with a pull-up; resolved here
`timescale 1ns/1ns
interface serial_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;

  // pull-up wins unless an enabled driver pulls low
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~(sda_host_oe & ~sda_host_o) & ~(sda_dev_oe & ~sda_dev_o);

  modport host (
    output scl_o, scl_oe, sda_host_o, sda_host_oe,
    input scl, sda
  );
  modport dev (
    output sda_dev_o, sda_dev_oe,
    input scl, sda
  );
endinterface

// ---- hw/sync2.sv ----
// two flip-flop synchroniser for levels entering a clock domain
// assumes: each bit is a level that holds for several destination edges
`timescale 1ns/1ns
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule // sync2

// ---- hw/clkgen_serial_host.sv ----
// bus master end: runs byte and block transfers to the synthesizer port
// assumes: one request at a time; write data offered on wr_valid_in
`timescale 1ns/1ns
module clkgen_serial_host import clkgen_pkg::*; (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic compat_mode_in,
  input wire logic req_valid_in,
  input wire xfer_kind_t kind_in,
  input wire logic [6:0] offset_in,
  input wire logic [7:0] len_in,
  input wire logic wr_valid_in,
  input wire logic [7:0] wr_data_in,
  serial_link_if.host link,
  output logic req_ready_out,
  output logic wr_ready_out,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic done_out,
  output logic nack_out
);
  localparam logic [8:0] QLAST = 9'(`SCL_QUARTER_CYC - 1);

  host_t s;
  host_t n;
  logic sda_s;
  logic tick;
  logic blk;
  logic rdb;
  logic ackdrv;

  sync2 #(.W(1), .RST_VAL(1'b1)) u_sda_sync (
    .clk_in(clk_in),
    .rst_in(sys_rst_in),
    .d_in(link.sda),
    .q_out(sda_s)
  );

  assign tick = (s.div == QLAST);
  assign blk = (s.kind == XF_BLK_WR) || (s.kind == XF_BLK_RD);
  assign req_ready_out = (s.st == HS_IDLE);
  assign wr_ready_out = (s.st == HS_WLOAD);

  always_comb begin
    n = s;
    n.rd_valid = 1'b0;
    n.done = 1'b0;
    case (s.st)
      HS_IDLE: begin
        if (req_valid_in) begin
          n.st = HS_START;
          n.kind = kind_in;
          n.ofs = offset_in;
          n.rem = (kind_in == XF_BLK_WR || kind_in == XF_BLK_RD)
                  ? len_in : 8'h01;
          n.compat = compat_mode_in;
          n.nacked = 1'b0;
          n.q = 2'h0;
          n.bitn = 4'h0;
          n.div = 9'h000;
        end
      end
      HS_WLOAD: begin
        if (wr_valid_in) begin
          n.tx = wr_data_in;
          n.st = HS_WDATA;
        end
      end
      default: begin
        if (!tick) begin
          n.div = s.div + 9'h001;
        end else begin
          n.div = 9'h000;
          n.q = s.q + 2'h1;
          if (s.q == 2'h2 && s.bitn < 4'h8) begin
            n.rx = {s.rx[6:0], sda_s};
          end
          if (s.q == 2'h2 && s.bitn == 4'h8
              && s.st != HS_RCOUNT && s.st != HS_RDATA) begin
            n.nacked = sda_s;
          end
          if (s.q == 2'h3) begin
            n.bitn = s.bitn + 4'h1;
            if (s.st == HS_START || s.st == HS_RSTART
                || s.st == HS_STOP || s.bitn == 4'h8) begin
              n.bitn = 4'h0;
              case (s.st)
                HS_START: begin
                  n.st = HS_ADDRW;
                  n.tx = `ADDR_BYTE_WR;
                end
                HS_ADDRW: begin
                  n.st = s.nacked ? HS_STOP : HS_CMD;
                  // block commands carry zero offset bits
                  n.tx = {~blk, blk ? 7'h00 : s.ofs};
                end
                HS_CMD: begin
                  if (s.nacked) begin
                    n.st = HS_STOP;
                  end else if (s.kind == XF_BYTE_RD || s.kind == XF_BLK_RD) begin
                    n.st = HS_RSTART;
                  end else if (blk && !s.compat) begin
                    n.st = HS_COUNT;
                    n.tx = s.rem;
                  end else begin
                    n.st = (s.rem == 8'h00) ? HS_STOP : HS_WLOAD;
                  end
                end
                HS_COUNT: begin
                  n.st = (s.nacked || s.rem == 8'h00) ? HS_STOP : HS_WLOAD;
                end
                HS_WDATA: begin
                  n.rem = s.rem - 8'h01;
                  n.st = (s.nacked || s.rem == 8'h01)
                         ? HS_STOP : HS_WLOAD;
                end
                HS_RSTART: begin
                  n.st = HS_ADDRR;
                  n.tx = `ADDR_BYTE_RD;
                end
                HS_ADDRR: begin
                  n.st = s.nacked ? HS_STOP : (blk ? HS_RCOUNT : HS_RDATA);
                end
                HS_RCOUNT: begin
                  n.st = (s.rem == 8'h00) ? HS_STOP : HS_RDATA;
                end
                HS_RDATA: begin
                  n.rd_data = s.rx;
                  n.rd_valid = 1'b1;
                  n.rem = s.rem - 8'h01;
                  n.st = (s.rem == 8'h01) ? HS_STOP : HS_RDATA;
                end
                default: begin
                  n.st = HS_IDLE;
                  n.done = 1'b1;
                  n.err = s.nacked;
                end
              endcase
            end
          end
        end
      end
    endcase
    // wire levels for the coming quarter
    rdb = (n.st == HS_RCOUNT) || (n.st == HS_RDATA);
    ackdrv = (n.st == HS_RCOUNT) ? (n.rem != 8'h00)
                                 : (n.rem > 8'h01);
    case (n.st)
      HS_IDLE: begin
        n.scl_lvl = 1'b1;
        n.sda_lvl = 1'b1;
      end
      HS_WLOAD: begin
        n.scl_lvl = 1'b0;
        n.sda_lvl = 1'b1;
      end
      HS_START, HS_RSTART: begin
        n.scl_lvl = (n.q == 2'h1) || (n.q == 2'h2);
        n.sda_lvl = (n.q < 2'h2);
      end
      HS_STOP: begin
        n.scl_lvl = (n.q != 2'h0);
        n.sda_lvl = (n.q >= 2'h2);
      end
      default: begin
        n.scl_lvl = (n.q == 2'h1) || (n.q == 2'h2);
        if (n.bitn < 4'h8) begin
          n.sda_lvl = rdb | n.tx[~n.bitn[2:0]];
        end else begin
          n.sda_lvl = ~(rdb & ackdrv);
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s <= '{st: HS_IDLE, q: 2'h0, bitn: 4'h0, div: 9'h000, tx: 8'h00,
             rx: 8'h00, rem: 8'h00, kind: XF_BYTE_WR, ofs: 7'h00,
             compat: 1'b0, nacked: 1'b0, scl_lvl: 1'b1, sda_lvl: 1'b1,
             rd_data: 8'h00, rd_valid: 1'b0, done: 1'b0, err: 1'b0};
    end else if (ce_in) begin
      s <= n;
    end
  end

  assign link.scl_o = 1'b0;
  assign link.scl_oe = ~s.scl_lvl;
  assign link.sda_host_o = 1'b0;
  assign link.sda_host_oe = ~s.sda_lvl;
  assign rd_data_out = s.rd_data;
  assign rd_valid_out = s.rd_valid;
  assign done_out = s.done;
  assign nack_out = s.err;
endmodule // clkgen_serial_host

// ---- sim/clkgen_link_props.sv ----
// checker on the two-wire link between the host and the synthesizer port
// assumes: sampled on clk_in, which oversamples both wires
`timescale 1ns/1ns
`include "clkgen_defines.svh"
module clkgen_link_props (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_p;
  logic sda_p;
  logic rd;
  logic blk;
  logic [7:0] bitc;
  logic [7:0] sh;
  wire start_c = scl && scl_p && sda_p && !sda;
  wire stop_c = scl && scl_p && !sda_p && sda;
  wire rise_c = scl && !scl_p;
  wire fall_c = !scl && scl_p;
  wire ackbit = (bitc % 8'h09) == 8'h08;
  wire dev_pull = sda_dev_oe && !sda_dev_o;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  // bit position since the last start, direction and mode of the frame
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
      bitc <= 8'h00;
      sh <= 8'h00;
      rd <= 1'b0;
      blk <= 1'b0;
    end else begin
      scl_p <= scl;
      sda_p <= sda;
      if (start_c || stop_c) begin
        bitc <= 8'h00;
      end else if (rise_c) begin
        bitc <= bitc + 8'h01;
        sh <= {sh[6:0], sda};
        if (bitc == 8'h07) begin
          rd <= sda;
        end
        if (bitc == 8'h09 && !rd) begin
          blk <= !sda;
        end
      end
    end
  end

  a_addr_msb_first: assert property (rise_c && bitc == 8'h08 |->
    sh[7:1] == `DEV_ADDR7) else $error("address byte wrong");
  a_addr_ack: assert property (rise_c && bitc == 8'h08 |-> !sda)
    else $error("address not acknowledged");
  a_write_acks: assert property (rise_c && ackbit && !rd |-> !sda)
    else $error("write byte not acknowledged");
  a_dev_quiet_wr: assert property (rise_c && !ackbit && (!rd ||
    bitc < 8'h09) |-> !dev_pull) else $error("device drove a host bit");
  a_blk_count: assert property (rise_c && bitc == 8'h11 && rd && blk
    |-> sh == {1'b0, `REG_COUNT}) else $error("block count wrong");
  a_blk_cmd_zero: assert property (rise_c && bitc == 8'h11 && !rd
    && !sh[7] |-> sh[6:0] == 7'h00) else $error("block offset bits set");
  a_dev_stable_hi: assert property (scl && $past(scl) |->
    $stable(sda_dev_oe)) else $error("device moved data while clock high");
  a_ack_release: assert property (fall_c && !rd && bitc != 8'h00 &&
    (bitc % 8'h09) == 8'h00 |-> ##[1:30] !dev_pull)
    else $error("device held the line after ack");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");

  c_start: cover property (start_c);
  c_blk_count: cover property (rise_c && bitc == 8'h11 && rd && blk);
  c_blk_cmd: cover property (rise_c && bitc == 8'h11 && !rd && !sh[7]);
endmodule // clkgen_link_props

// ---- sim/test_clock_gen_serial_config.sv ----
// bench: host end and synthesizer port joined by the link interface
// assumes: hw files compiled first, clkgen_defines.svh on include path
`timescale 1ns/1ns
`include "clkgen_defines.svh"
module test_clock_gen_serial_config import clkgen_pkg::*;;
  logic clk_in, link_clk, sys_rst, ce, compat, req_valid, wr_valid;
  xfer_kind_t kind;
  logic [6:0] offset;
  logic [7:0] len, wr_data, rd_data, fabric, misc, busclk, d;
  logic req_ready, wr_ready, rd_valid, done, nack, spread;
  logic [31:0] lfsr = 32'h7AAB;
  int error_cnt = 0;
  int tests_run = 0;
  int m[3];
  int wq[$];
  int rq[$];

  serial_link_if link();
  clkgen_serial_dev u_clkgen_serial_dev (.clk_in(clk_in),
    .sys_rst_in(sys_rst), .ce_in(ce), .compat_mode_in(compat),
    .link_clk_in(link_clk), .link(link), .fabric_pair_enables_out(fabric),
    .misc_output_and_spread_control_out(misc),
    .bus_clock_enables_out(busclk), .spread_enable_out(spread));
  clkgen_serial_host u_clkgen_serial_host (.clk_in(clk_in),
    .sys_rst_in(sys_rst), .ce_in(ce), .compat_mode_in(compat),
    .req_valid_in(req_valid), .kind_in(kind), .offset_in(offset),
    .len_in(len), .wr_valid_in(wr_valid), .wr_data_in(wr_data),
    .link(link), .req_ready_out(req_ready), .wr_ready_out(wr_ready),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid), .done_out(done),
    .nack_out(nack));
  clkgen_link_props u_clkgen_link_props (.clk_in(clk_in),
    .sys_rst_in(sys_rst), .scl_o(link.scl_o), .scl_oe(link.scl_oe),
    .sda_host_o(link.sda_host_o), .sda_host_oe(link.sda_host_oe),
    .sda_dev_o(link.sda_dev_o), .sda_dev_oe(link.sda_dev_oe),
    .scl(link.scl), .sda(link.sda));

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check_outs;
    check(fabric, 8'(m[0]), "byte 0");
    check(misc, 8'(m[1]), "byte 1");
    check(busclk, 8'(m[2]), "byte 2");
    check({7'h00, spread}, 8'(m[1] & 1), "spread");
  endtask

  // one request; write data comes from wq, read data is checked against rq
  task automatic xfer(input xfer_kind_t k, input logic [6:0] ofs,
                      input logic [7:0] n, input logic cm);
    int i;
    req_valid <= 1'b1;
    kind <= k;
    offset <= ofs;
    len <= n;
    compat <= cm;
    wr_valid <= (wq.size() != 0);
    if (wq.size() != 0) wr_data <= 8'(wq[0]);
    @(posedge clk_in);
    req_valid <= 1'b0;
    for (i = 0; i < 20000; i++) begin
      @(posedge clk_in);
      if (wr_ready === 1'b1 && wr_valid === 1'b1) begin
        void'(wq.pop_front());
        wr_valid <= (wq.size() != 0);
        if (wq.size() != 0) wr_data <= 8'(wq[0]);
      end
      if (rd_valid === 1'b1 && rq.size() != 0) begin
        check(rd_data, 8'(rq.pop_front()), "read data");
      end else if (rd_valid === 1'b1) begin
        check(rd_data, 8'h00, "extra read byte");
        check(rd_data, 8'hFF, "extra read byte");
      end
      if (done === 1'b1) break;
    end
    check({7'h00, done}, 8'h01, "transfer done");
    check({7'h00, req_ready}, 8'h01, "host not idle");
    check({7'h00, nack}, 8'h00, "nack seen");
    repeat (20) @(posedge clk_in);
    check_outs();
  endtask

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial begin
    link_clk = 1'b0;
    #2;
    forever #3 link_clk = ~link_clk;
  end

  initial begin
    #800000;
    error_cnt++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    final_report();
  end

  initial begin
    sys_rst = 1'b1;
    ce = 1'b1;
    compat = 1'b0;
    req_valid = 1'b0;
    kind = XF_BYTE_WR;
    offset = 7'h00;
    len = 8'h00;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    m[0] = `RST_FABRIC;
    m[1] = `RST_MISC;
    m[2] = `RST_BUSCLK;
    repeat (16) @(posedge clk_in);
    sys_rst <= 1'b0;
    repeat (5) @(posedge clk_in);
    check_outs();
    // byte write turning spread on, reserved bit kept at its default
    lfsr = lfsr_next(lfsr);
    d = (lfsr[7:0] & 8'hF6) | 8'h01;
    m[1] = d;
    wq.push_back(d);
    xfer(XF_BYTE_WR, `OFS_MISC, 8'h01, 1'b0);
    // compatibility block write: first byte after command is data
    lfsr = lfsr_next(lfsr);
    m[0] = lfsr[15:8];
    wq.push_back(m[0]);
    xfer(XF_BLK_WR, 7'h00, 8'h01, 1'b1);
    // block read of the two lowest bytes
    rq.push_back(m[0]);
    rq.push_back(m[1]);
    xfer(XF_BLK_RD, 7'h00, 8'h02, 1'b0);
    check(8'(rq.size()), 8'h00, "read bytes missing");
    // block write of all three bytes through the count phase
    lfsr = lfsr_next(lfsr);
    m[0] = lfsr[7:0];
    m[1] = lfsr[15:8] & 8'hF7;
    m[2] = lfsr[23:16] | 8'h0E;
    wq.push_back(m[0]);
    wq.push_back(m[1]);
    wq.push_back(m[2]);
    xfer(XF_BLK_WR, 7'h00, 8'h03, 1'b0);
    // byte reads: a mapped offset, then an unmapped one that reads zero
    rq.push_back(m[2]);
    xfer(XF_BYTE_RD, `OFS_BUSCLK, 8'h01, 1'b0);
    rq.push_back(0);
    xfer(XF_BYTE_RD, 7'h05, 8'h01, 1'b0);
    check(8'(rq.size()), 8'h00, "read bytes missing");
    final_report();
  end
endmodule // test_clock_gen_serial_config
